// ---- core/egqrl_regs.sv ----
// Purpose: Egress queue rate limit registers and per-port queue scheduling
// Assumes: Queue inputs come from logic on pclk
// Notes: Ports 2 to 4 map to local port 0 to 2
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module egqrl_regs
    import egqrl_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NPORT*NQ-1:0] q_pend,
    input wire logic [NPORT*NQ*LEN_W-1:0] q_len,
    input wire logic [NPORT*4-1:0] lower_ratio,
    input wire logic [NPORT-1:0] tx_ready,
    output logic [NPORT-1:0] grant,
    output logic [NPORT*2-1:0] grant_queue
);
    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    logic [6:0] rate_r [NPORT][3];
    logic [NPORT-1:0] four_q_r;
    logic [NPORT-1:0] limited;
    logic [NPORT-1:0] shaper_ok;
    logic [NPORT-1:0] grant_r;
    logic [NPORT*2-1:0] grant_q_r;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    logic [8:0] idx;
    logic hit;
    logic is_rate;
    logic is_fixed;
    logic [1:0] sel_port;
    logic [1:0] sel_q;
    logic [7:0] rd_val;
    logic wr_en;

    assign idx = paddr[10:2];
    assign wr_en = psel && penable && pwrite && is_rate;

    always_comb begin
        hit = 1'b1;
        is_rate = 1'b0;
        is_fixed = 1'b0;
        sel_port = 2'd0;
        sel_q = 2'd0;
        unique case (idx)
            IDX_P2_Q1: begin
                is_rate = 1'b1;
            end
            IDX_P3_Q1: begin
                is_rate = 1'b1;
                sel_port = 2'd1;
            end
            IDX_P4_Q1: begin
                is_rate = 1'b1;
                sel_port = 2'd2;
            end
            IDX_P2_Q2: begin
                is_rate = 1'b1;
                sel_q = 2'd1;
            end
            IDX_P3_Q2: begin
                is_rate = 1'b1;
                sel_port = 2'd1;
                sel_q = 2'd1;
            end
            IDX_P4_Q2: begin
                is_rate = 1'b1;
                sel_port = 2'd2;
                sel_q = 2'd1;
            end
            IDX_P2_Q3: begin
                is_rate = 1'b1;
                sel_q = 2'd2;
            end
            IDX_P3_Q3: begin
                is_rate = 1'b1;
                sel_port = 2'd1;
                sel_q = 2'd2;
            end
            IDX_P4_Q3: begin
                is_rate = 1'b1;
                sel_port = 2'd2;
                sel_q = 2'd2;
            end
            IDX_TEST, IDX_RSVD: begin
                is_fixed = 1'b1;
            end
            IDX_MODE, IDX_STAT: begin
                hit = 1'b1;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    always_comb begin
        rd_val = 8'h00;
        if (is_rate) begin
            rd_val = {1'b0, rate_r[sel_port][sel_q]};
        end else if (idx == IDX_TEST) begin
            rd_val = TEST_VAL;
        end else if (idx == IDX_RSVD) begin
            rd_val = RSVD_VAL;
        end else if (idx == IDX_MODE) begin
            rd_val = {5'h00, four_q_r};
        end else if (idx == IDX_STAT) begin
            rd_val = {2'b00, limited, shaper_ok};
        end
    end

    // Zero wait state slave
    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit;
    assign prdata = (psel && penable && !pwrite && hit) ? {24'h00_0000, rd_val} : 32'h0000_0000;

    // ------------------------------------------------------------
    // Rate code registers
    // ------------------------------------------------------------
    // writable codes, zero reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int p = 0; p < NPORT; p++) begin
                for (int k = 0; k < 3; k++) begin
                    rate_r[p][k] <= RATE_RST;
                end
            end
        end else if (wr_en) begin
            rate_r[sel_port][sel_q] <= pwdata[RATE_MSB:0];
        end
    end

    // Queue mode bit per port
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            four_q_r <= MODE_RST;
        end else if (psel && penable && pwrite && idx == IDX_MODE) begin
            four_q_r <= pwdata[NPORT-1:0];
        end
    end

    // ------------------------------------------------------------
    // Per-port scheduling
    // ------------------------------------------------------------
    genvar gp;
    generate
        for (gp = 0; gp < NPORT; gp++) begin : g_port
            logic [NQ-1:0] pend;
            logic [NQ-1:0] elig;
            logic [1:0] top_q;
            logic [1:0] win_q;
            logic [1:0] pick_q;
            logic any;
            logic lower_any;
            logic [1:0] lower_q;
            logic [3:0] ratio;
            logic [3:0] cnt_r;
            logic [6:0] top_code;
            logic [LEN_W-1:0] top_len;
            logic take;

            assign pend = q_pend[gp*NQ +: NQ];
            assign ratio = lower_ratio[gp*4 +: 4];
            assign top_q = four_q_r[gp] ? 2'd3 : 2'd1;
            assign top_code = four_q_r[gp] ? rate_r[gp][2] : rate_r[gp][0];
            assign top_len = q_len[(gp*NQ + 32'(top_q))*LEN_W +: LEN_W];
            assign take = tx_ready[gp] && any && !grant_r[gp];

            // exact rate on top queue only
            egqrl_shaper u_shaper (
                .pclk(pclk),
                .presetn(presetn),
                .code(top_code),
                .consume(take && pick_q == top_q),
                .len(top_len),
                .ok(shaper_ok[gp]),
                .limited(limited[gp])
            );

            always_comb begin
                elig = pend;
                if (!four_q_r[gp]) begin
                    elig[3:2] = 2'b00;
                end
                if (!shaper_ok[gp]) begin
                    elig[top_q] = 1'b0;
                end
            end

            always_comb begin
                any = 1'b1;
                win_q = 2'd0;
                if (elig[3]) begin
                    win_q = 2'd3;
                end else if (elig[2]) begin
                    win_q = 2'd2;
                end else if (elig[1]) begin
                    win_q = 2'd1;
                end else if (!elig[0]) begin
                    any = 1'b0;
                end
            end

            always_comb begin
                lower_any = 1'b1;
                lower_q = 2'd0;
                if (win_q > 2'd2 && elig[2]) begin
                    lower_q = 2'd2;
                end else if (win_q > 2'd1 && elig[1]) begin
                    lower_q = 2'd1;
                end else if (!(win_q > 2'd0 && elig[0])) begin
                    lower_any = 1'b0;
                end
            end

            assign pick_q = (lower_any && ratio != 4'h0 && cnt_r >= ratio) ? lower_q : win_q;

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    cnt_r <= 4'h0;
                end else if (take) begin
                    if (pick_q != win_q || !lower_any) begin
                        cnt_r <= 4'h0;
                    end else if (cnt_r != 4'hF) begin
                        cnt_r <= cnt_r + 4'h1;
                    end
                end
            end

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    grant_r[gp] <= 1'b0;
                    grant_q_r[gp*2 +: 2] <= 2'd0;
                end else begin
                    grant_r[gp] <= take;
                    if (take) begin
                        grant_q_r[gp*2 +: 2] <= pick_q;
                    end
                end
            end
        end
    endgenerate

    assign grant = grant_r;
    assign grant_queue = grant_q_r;
endmodule : egqrl_regs
`default_nettype wire

// ---- core/egqrl_shaper.sv ----
// Purpose: Credit bucket for one shaped egress queue
// Assumes: consume only when ok is high
// Notes: Unlimited codes hold the bucket full
`timescale 1ns/1ps
`default_nettype none
module egqrl_shaper
    import egqrl_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [6:0] code,
    input wire logic consume,
    input wire logic [LEN_W-1:0] len,
    output logic ok,
    output logic limited
);
    logic [CRED_W-1:0] credit_r;
    logic [CRED_W-1:0] credit_nxt;
    logic [CRED_W-1:0] inc;
    logic [CRED_W-1:0] cost;
    logic [CRED_W:0] sum;

    assign limited = (code != CODE_OFF) && (code != CODE_FULL) && (code <= CODE_128K);
    assign cost = CRED_W'({18'h0, len} * COST_PER_BYTE);
    assign ok = !limited || (credit_r >= cost);

    always_comb begin
        inc = CRED_W'({22'h0, code} * KBPS_PER_MBPS);
        if (code == CODE_64K) begin
            inc = INC_64K;
        end else if (code == CODE_128K) begin
            inc = INC_128K;
        end
        sum = {1'b0, credit_r} + {1'b0, inc};
        if (consume) begin
            sum = sum - {1'b0, cost};
        end
        if (!limited || sum > {1'b0, CRED_CAP}) begin
            credit_nxt = CRED_CAP;
        end else begin
            credit_nxt = sum[CRED_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            credit_r <= CRED_CAP;
        end else begin
            credit_r <= credit_nxt;
        end
    end
endmodule : egqrl_shaper
`default_nettype wire

// ---- pkg/egqrl_pkg.sv ----
// Purpose: Constants for the egress queue rate limit register bank
// Assumes: APB word addressing, register index times four is the byte address
// Notes: Rates counted in 1/10000 bit per 100 ns clock
//
// Overview of operation
// - Queue 1 seven-bit rate code, resets zero
// - Queue 2 seven-bit rate code, bit seven zero
// - Queue 3 seven-bit rate code, bit seven zero
// - Shape top queue traffic (queue 3, or queue 1 with two queues) to coded rate
// - Four queues: queue 1 second lowest
// - Two queues: queue 1 above queue 0
// - Four queues: queue 2 second highest
// - Four queues: queue 3 highest priority
// - Codes 1-99 give Mbps; 0, 100 unlimited
// - Code 101 64 kbps, 102 128 kbps
// - Only top queue exact; lower by ratio
package egqrl_pkg;
    localparam int NPORT = 3;
    localparam int NQ = 4;
    localparam int LEN_W = 11;
    localparam int CRED_W = 29;
    // Register indices, byte address is four times the index
    localparam logic [8:0] IDX_TEST = 9'h0BF;
    localparam logic [8:0] IDX_RSVD = 9'h0CF;
    localparam logic [8:0] IDX_P2_Q2 = 9'h0CD;
    localparam logic [8:0] IDX_P2_Q3 = 9'h0CE;
    localparam logic [8:0] IDX_P3_Q2 = 9'h0DD;
    localparam logic [8:0] IDX_P3_Q3 = 9'h0DE;
    localparam logic [8:0] IDX_P4_Q2 = 9'h0ED;
    localparam logic [8:0] IDX_P4_Q3 = 9'h0EE;
    localparam logic [8:0] IDX_P2_Q1 = 9'h100;
    localparam logic [8:0] IDX_P3_Q1 = 9'h101;
    localparam logic [8:0] IDX_P4_Q1 = 9'h102;
    localparam logic [8:0] IDX_MODE = 9'h104;
    localparam logic [8:0] IDX_STAT = 9'h105;
    // Reset and fixed values
    localparam logic [7:0] TEST_VAL = 8'h80;
    localparam logic [7:0] RSVD_VAL = 8'h15;
    localparam logic [6:0] RATE_RST = 7'h00;
    localparam logic [2:0] MODE_RST = 3'h0;
    // Rate code field
    localparam int RATE_MSB = 6;
    localparam logic [6:0] CODE_OFF = 7'h00;
    localparam logic [6:0] CODE_MAX_MBPS = 7'h63;
    localparam logic [6:0] CODE_FULL = 7'h64;
    localparam logic [6:0] CODE_64K = 7'h65;
    localparam logic [6:0] CODE_128K = 7'h66;
    // Timing: credit per clock equals the rate in kbps at 100 ns per clock
    localparam int CLK_NS = 100;
    localparam logic [CRED_W-1:0] KBPS_PER_MBPS = 29'h0000_03E8;
    localparam logic [CRED_W-1:0] INC_64K = 29'h0000_0040;
    localparam logic [CRED_W-1:0] INC_128K = 29'h0000_0080;
    localparam logic [CRED_W-1:0] COST_PER_BYTE = 29'h0001_3880;
    localparam logic [CRED_W-1:0] CRED_CAP = 29'h0989_6800;
endpackage : egqrl_pkg

// ---- test/egqrl_regs_sva.sv ----
// Purpose: Port checks for egqrl_regs
// Assumes: Zero wait APB, local port 0 watched
// Notes: Bound to every egqrl_regs instance
`timescale 1ns/1ps
`default_nettype none
module egqrl_regs_sva
    import egqrl_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [NPORT*NQ-1:0] q_pend,
    input wire logic [NPORT*NQ*LEN_W-1:0] q_len,
    input wire logic [NPORT*4-1:0] lower_ratio,
    input wire logic [NPORT-1:0] tx_ready,
    input wire logic [NPORT-1:0] grant,
    input wire logic [NPORT*2-1:0] grant_queue
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic rd;
    logic [8:0] idx;
    assign rd = psel && penable && !pwrite;
    assign idx = paddr[10:2];
    acc_ready_a: assert property (psel && penable |-> pready)
        else $error("pready low in access");
    q1_upper_a: assert property (rd && idx == IDX_P2_Q1 |-> prdata[31:7] == '0)
        else $error("queue1 upper bits set");
    q2_upper_a: assert property (rd && idx == IDX_P3_Q2 |-> prdata[31:7] == '0)
        else $error("queue2 upper bits set");
    q3_upper_a: assert property (rd && idx == IDX_P4_Q3 |-> prdata[31:7] == '0)
        else $error("queue3 upper bits set");
    test_fixed_a: assert property (rd && idx == IDX_TEST |-> prdata == 32'(TEST_VAL))
        else $error("test value wrong");
    rsvd_fixed_a: assert property (rd && idx == IDX_RSVD |-> prdata == 32'(RSVD_VAL))
        else $error("reserved value wrong");
    idle_quiet_a: assert property (!(psel && penable) |-> !pslverr && prdata == '0)
        else $error("bus output outside access");
    grant_gap_a: assert property (grant[0] |=> !grant[0])
        else $error("grants too close");
    grant_cause_a: assert property (grant[0] |-> $past(tx_ready[0]) && $past(|q_pend[3:0]))
        else $error("grant without request");
    queue_hold_a: assert property (!grant[0] |-> $stable(grant_queue[1:0]))
        else $error("queue moved without grant");
endmodule : egqrl_regs_sva
bind egqrl_regs egqrl_regs_sva sva_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .q_pend(q_pend), .q_len(q_len), .lower_ratio(lower_ratio), .tx_ready(tx_ready),
    .grant(grant), .grant_queue(grant_queue)
);
`default_nettype wire

// ---- test/testbench.sv ----
// Purpose: Register and scheduler bench for egqrl_regs
// Assumes: APB master tasks, local port 0 traffic
// Notes: Ratio input held at strict priority until the last checks, which set port 0 ratio to 1
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module testbench import egqrl_pkg::*;;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [NPORT*NQ-1:0] q_pend;
    logic [NPORT*NQ*LEN_W-1:0] q_len;
    logic [NPORT*4-1:0] lower_ratio;
    logic [NPORT-1:0] tx_ready, grant;
    logic [NPORT*2-1:0] grant_queue;
    int fail_count, n_checks, k;
    logic [8:0] ri [9] = '{IDX_P2_Q1, IDX_P3_Q1, IDX_P4_Q1, IDX_P2_Q2, IDX_P2_Q3,
        IDX_P3_Q2, IDX_P3_Q3, IDX_P4_Q2, IDX_P4_Q3};
    logic [6:0] codes [8] = '{RATE_RST, CODE_64K, CODE_FULL, CODE_128K, CODE_OFF, 7'h01,
        CODE_FULL, CODE_MAX_MBPS};
    egqrl_regs uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .q_pend(q_pend), .q_len(q_len), .lower_ratio(lower_ratio),
        .tx_ready(tx_ready), .grant(grant), .grant_queue(grant_queue));
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    task wrap_up;
        if (fail_count == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : wrap_up
    task apb(input logic w, input logic [8:0] ix, input logic [31:0] wd);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {1'b0, ix, 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (i == 20) begin
            fail_count++;
            wrap_up();
        end
    endtask : apb
    task sched(input logic [3:0] pend, input logic [1:0] q);
        int i;
        q_pend[3:0] <= pend;
        tx_ready[0] <= 1'b1;
        for (i = 0; i < 40; i++) begin
            @(posedge pclk);
            if (grant[0] === 1'b1) break;
        end
        `CHK("grant_queue", q, grant_queue[1:0])
        q_pend[3:0] <= 4'h0;
        tx_ready[0] <= 1'b0;
        if (i == 40) begin
            fail_count++;
            wrap_up();
        end
        @(posedge pclk);
    endtask : sched
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, q_pend, tx_ready, lower_ratio} = '0;
        fail_count = 0;
        n_checks = 0;
        q_len = {NPORT*NQ{11'h040}};
        q_len[3*LEN_W +: LEN_W] = 11'h7D0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        for (k = 0; k < 9; k++) begin
            apb(1'b0, ri[k], 32'h0000_0000);
            `CHK("rate_reset", 32'h0000_0000, rd)
            apb(1'b1, ri[k], 32'hFFFF_FF90 + 32'(k));
        end
        for (k = 0; k < 9; k++) begin
            apb(1'b0, ri[k], 32'h0000_0000);
            `CHK("rate_rw", 32'h0000_0010 + 32'(k), rd)
            apb(1'b1, ri[k], 32'h0000_0000);
        end
        apb(1'b1, IDX_TEST, 32'h0000_0000);
        apb(1'b0, IDX_TEST, 32'h0000_0000);
        `CHK("test_reg", 32'(TEST_VAL), rd)
        apb(1'b1, IDX_RSVD, 32'hFFFF_FFFF);
        apb(1'b0, IDX_RSVD, 32'h0000_0000);
        `CHK("rsvd_reg", 32'(RSVD_VAL), rd)
        `CHK("slverr_ok", 1'b0, er)
        apb(1'b0, 9'h0C0, 32'h0000_0000);
        `CHK("slverr_bad", 1'b1, er)
        sched(4'h3, 2'h1);
        apb(1'b1, IDX_MODE, 32'h0000_0001);
        sched(4'hF, 2'h3);
        sched(4'h7, 2'h2);
        sched(4'h3, 2'h1);
        for (k = 0; k < 8; k++) begin
            apb(1'b1, IDX_P2_Q3, 32'(codes[k]));
            sched(4'h9, 2'h3);
            sched(4'h9, (codes[k] == CODE_OFF || codes[k] == CODE_FULL) ? 2'h3 : 2'h0);
        end
        apb(1'b0, IDX_STAT, 32'h0000_0000);
        `CHK("status", 32'h0000_000E, rd)
        apb(1'b0, IDX_MODE, 32'h0000_0000);
        `CHK("mode", 32'h0000_0001, rd)
        apb(1'b1, IDX_P2_Q3, 32'(CODE_OFF));
        lower_ratio[3:0] <= 4'h1;
        sched(4'h9, 2'h3);
        sched(4'h9, 2'h0);
        sched(4'h9, 2'h3);
        wrap_up();
    end
endmodule : testbench
`default_nettype wire
